// ===== design/itwc_params.svh
// Offsets, field positions, reset values and counts of the interval timer
// with watch clock. Assumes inclusion by bare name from the design files.
`ifndef ITWC_PARAMS_SVH
`define ITWC_PARAMS_SVH

// Register byte offsets on the register bus.
`define ITWC_OFS_MODE 8'h00
`define ITWC_OFS_CMP 8'h04
`define ITWC_OFS_WMODE 8'h08
`define ITWC_OFS_STAT 8'h0C
`define ITWC_OFS_MASK 8'h10
`define ITWC_OFS_COUNT 8'h14

// Interval mode control fields.
`define ITWC_MODE_RUN_BIT 4
`define ITWC_MODE_DIS_BIT 2
`define ITWC_MODE_SEL_HI 1
`define ITWC_MODE_SEL_LO 0
`define ITWC_MODE_WMASK 8'h17
`define ITWC_MODE_RESET 8'h00
`define ITWC_CMP_RESET 8'h00
`define ITWC_CNT_RELOAD 8'h01
`define ITWC_CMP_ONCE 8'h01

// Watch mode control fields.
`define ITWC_WMODE_EN_BIT 0
`define ITWC_WMODE_RUN_BIT 1
`define ITWC_WMODE_PER_LO 2
`define ITWC_WMODE_PER_HI 3
`define ITWC_WMODE_IVL_LO 4
`define ITWC_WMODE_IVL_HI 6
`define ITWC_WMODE_SRC_BIT 7
`define ITWC_WMODE_RESET 8'h00

// Watch counting figures.
`define ITWC_WCNT_SLOW_TAP 4'h9
`define ITWC_WIVL_BASE_TAP 4'h4

// Interrupt status and mask bits.
`define ITWC_IRQ_W 3
`define ITWC_IRQ_MATCH 0
`define ITWC_IRQ_WPER 1
`define ITWC_IRQ_WIVL 2
`define ITWC_IRQ_RESET 3'h0

`endif

// ===== design/itwc_pkg.sv
// Types shared by the interval timer with watch clock.
// Assumes the params header carries every numeric constant.
package itwc_pkg;

  typedef enum logic [1:0] {
    ITWC_RESP_OKAY,
    ITWC_RESP_EXOKAY,
    ITWC_RESP_SLVERR,
    ITWC_RESP_DECERR
  } itwc_resp_t;

  typedef logic [7:0] itwc_byte_t;

endpackage : itwc_pkg

// ===== design/itwc_top.sv
// Interval timer with a generated watch clock and a watch timer, reached
// over AXI4-Lite. Assumes SYS_CLK at 100 MHz, synchronous RESETN and a
// free-running low-frequency subclock on SUBCLK from outside the domain.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "itwc_params.svh"

// Behaviour
// - A three-stage prescaler gives main clock over two, four and eight.
// - Select field 00/01/10/11 picks main clock, half, quarter, eighth.
// - With run-enable clear the interval counter stops and holds 01H.
// - Setting run-enable starts counting pulses of the chosen clock.
// - Counter equal to compare raises interrupt, reloads 01H, keeps on.
// - Compare value 00H acts as a count of 256.
// - Compare value 01H raises the interval interrupt only once.
// - Watch clock supplied only when running and supply not disabled.
// - Watch clock is main clock over two to m plus one times N.
// - Mode register takes byte or bit writes; compare only whole bytes.
// - Reset clears mode and compare registers to 00H.
// - Watch working clock comes from generated clock or subclock.
// - Eleven-stage watch prescaler gives taps over 2^4 to 2^11.
// - Five-bit counter raises watch interrupt every 2^4,2^5,2^13,2^14.
// - Watch period and watch interval interrupts run independently.
// - Watch counts with enable and run set; both clear resets counters.
module itwc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SUBCLK,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic WATCH_CLK_OUT,
  output logic IRQ
);

  // True when the low n bits of v are all ones; n of zero is always true.
  function automatic logic low_ones(input logic [10:0] v,
                                    input logic [3:0] n);
    logic [10:0] m;
    m = (11'h001 << n) - 11'h001;
    return &(v | ~m);
  endfunction : low_ones

  // Decodes a word address onto one register offset.
  function automatic logic hits(input logic [ADDR_W-1:0] a,
                                input logic [7:0] ofs);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[7:2]);
  endfunction : hits

  // Register file.
  itwc_pkg::itwc_byte_t mode_reg;
  itwc_pkg::itwc_byte_t cmp_reg;
  itwc_pkg::itwc_byte_t wmode_reg;
  logic [`ITWC_IRQ_W-1:0] stat_reg;
  logic [`ITWC_IRQ_W-1:0] mask_reg;

  // Bus slave state.
  logic aw_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic w_full_reg;
  logic [7:0] wdata_reg;
  logic wlane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Interval timer state.
  logic [2:0] presc_reg;
  logic [7:0] cnt_reg;
  logic once_reg;
  logic tog_reg;
  logic wclk_out_reg;

  // Watch timer state.
  logic sub_s1_reg;
  logic sub_s2_reg;
  logic sub_s3_reg;
  logic [10:0] wpresc_reg;
  logic [4:0] wcnt_reg;

  // Write decode.
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_byte = do_write && wlane0_reg;
  wire wr_mode = wr_byte && hits(awaddr_reg, `ITWC_OFS_MODE);
  wire wr_cmp = wr_byte && hits(awaddr_reg, `ITWC_OFS_CMP);
  wire wr_wmode = wr_byte && hits(awaddr_reg, `ITWC_OFS_WMODE);
  wire wr_stat = wr_byte && hits(awaddr_reg, `ITWC_OFS_STAT);
  wire wr_mask = wr_byte && hits(awaddr_reg, `ITWC_OFS_MASK);
  wire wr_mapped = hits(awaddr_reg, `ITWC_OFS_MODE)
                || hits(awaddr_reg, `ITWC_OFS_CMP)
                || hits(awaddr_reg, `ITWC_OFS_WMODE)
                || hits(awaddr_reg, `ITWC_OFS_STAT)
                || hits(awaddr_reg, `ITWC_OFS_MASK)
                || hits(awaddr_reg, `ITWC_OFS_COUNT);

  // Interval timer controls.
  wire run = mode_reg[`ITWC_MODE_RUN_BIT];
  wire supply_dis = mode_reg[`ITWC_MODE_DIS_BIT];
  wire [1:0] clk_sel = mode_reg[`ITWC_MODE_SEL_HI:`ITWC_MODE_SEL_LO];

  // A count pulse every 2^m main clocks, m being the select value.
  wire count_tick = run
    && low_ones({8'h00, presc_reg}, {2'b00, clk_sel});
  // Compare value 00H matches once the counter has wrapped past FFH.
  wire cmp_match = cnt_reg == cmp_reg;
  wire match_tick = count_tick && cmp_match;
  wire ev_match = match_tick && !once_reg;
  wire supply_on = run && !supply_dis;
  // Rising edge of the generated watch clock, one per two matches.
  wire brg_rise = supply_on && match_tick && !tog_reg;

  // Watch timer controls.
  wire w_en = wmode_reg[`ITWC_WMODE_EN_BIT];
  wire w_run = wmode_reg[`ITWC_WMODE_RUN_BIT];
  wire w_src_brg = wmode_reg[`ITWC_WMODE_SRC_BIT];
  wire [1:0] per_sel = wmode_reg[`ITWC_WMODE_PER_HI:`ITWC_WMODE_PER_LO];
  wire [2:0] ivl_sel = wmode_reg[`ITWC_WMODE_IVL_HI:`ITWC_WMODE_IVL_LO];

  wire sub_rise = sub_s2_reg && !sub_s3_reg;
  wire wtick = w_src_brg ? brg_rise : sub_rise;
  wire w_count = w_en && w_run;
  // The five-bit counter runs on the working clock or on it over 2^9.
  wire wcnt_tick = w_count && wtick
    && (per_sel[1] || low_ones(wpresc_reg, `ITWC_WCNT_SLOW_TAP));
  wire wcnt_wrap = per_sel[0] ? &wcnt_reg[3:0] : &wcnt_reg;
  wire ev_wper = wcnt_tick && wcnt_wrap;
  wire [3:0] ivl_tap = {1'b0, ivl_sel} + `ITWC_WIVL_BASE_TAP;
  wire ev_wivl = w_en && wtick
    && low_ones(wpresc_reg, ivl_tap);

  // Events set status; a set in the clearing cycle wins.
  wire [`ITWC_IRQ_W-1:0] events = {ev_wivl, ev_wper, ev_match};
  wire [`ITWC_IRQ_W-1:0] stat_clr = wr_stat
    ? wdata_reg[`ITWC_IRQ_W-1:0] : `ITWC_IRQ_RESET;
  wire [`ITWC_IRQ_W-1:0] stat_next = (stat_reg & ~stat_clr) | events;

  // Next values of the timer state.
  wire [2:0] presc_next = run ? presc_reg + 3'h1 : 3'h0;
  wire [7:0] cnt_next = !run ? `ITWC_CNT_RELOAD
    : match_tick ? `ITWC_CNT_RELOAD
    : count_tick ? cnt_reg + 8'h01 : cnt_reg;
  wire once_next = run
    && (once_reg || (ev_match && cmp_reg == `ITWC_CMP_ONCE));
  wire tog_next = run && (tog_reg ^ match_tick);
  wire [10:0] wpresc_next = !w_en ? 11'h000
    : wtick ? wpresc_reg + 11'h001 : wpresc_reg;
  wire [4:0] wcnt_next = !w_count ? 5'h00
    : wcnt_tick ? wcnt_reg + 5'h01 : wcnt_reg;

  // Read decode.
  wire rd_take = S_AXI_ARVALID && !rvalid_reg;
  wire [ADDR_W-1:0] ra = S_AXI_ARADDR;
  wire [31:0] count_view = {11'h000, wclk_out_reg, 3'h0, wcnt_reg,
                            4'h0, cnt_reg};
  wire [31:0] rd_data =
      hits(ra, `ITWC_OFS_MODE) ? {24'h000000, mode_reg}
    : hits(ra, `ITWC_OFS_CMP) ? {24'h000000, cmp_reg}
    : hits(ra, `ITWC_OFS_WMODE) ? {24'h000000, wmode_reg}
    : hits(ra, `ITWC_OFS_STAT) ? {29'h00000000, stat_reg}
    : hits(ra, `ITWC_OFS_MASK) ? {29'h00000000, mask_reg}
    : hits(ra, `ITWC_OFS_COUNT) ? count_view
    : 32'h00000000;
  wire rd_mapped = hits(ra, `ITWC_OFS_MODE) || hits(ra, `ITWC_OFS_CMP)
    || hits(ra, `ITWC_OFS_WMODE) || hits(ra, `ITWC_OFS_STAT)
    || hits(ra, `ITWC_OFS_MASK) || hits(ra, `ITWC_OFS_COUNT);

  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign WATCH_CLK_OUT = wclk_out_reg;
  assign IRQ = |(stat_reg & mask_reg);

  // Registers take byte lane 0 only; a bit write arrives as a byte write
  // carrying the other bits unchanged, so both forms land alike.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mode_reg <= `ITWC_MODE_RESET;
      cmp_reg <= `ITWC_CMP_RESET;
      wmode_reg <= `ITWC_WMODE_RESET;
      mask_reg <= `ITWC_IRQ_RESET;
      stat_reg <= `ITWC_IRQ_RESET;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata_reg & `ITWC_MODE_WMASK;
      end
      if (wr_cmp) begin
        cmp_reg <= wdata_reg;
      end
      if (wr_wmode) begin
        wmode_reg <= wdata_reg;
      end
      if (wr_mask) begin
        mask_reg <= wdata_reg[`ITWC_IRQ_W-1:0];
      end
      stat_reg <= stat_next;
    end
  end

  // Write channels are taken in either order and joined here.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      aw_full_reg <= 1'b0;
      awaddr_reg <= '0;
      w_full_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wlane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA[7:0];
        wlane0_reg <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? itwc_pkg::ITWC_RESP_OKAY
                               : itwc_pkg::ITWC_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_mapped ? itwc_pkg::ITWC_RESP_OKAY
                             : itwc_pkg::ITWC_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Interval timer.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      presc_reg <= 3'h0;
      cnt_reg <= `ITWC_CNT_RELOAD;
      once_reg <= 1'b0;
      tog_reg <= 1'b0;
      wclk_out_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      cnt_reg <= cnt_next;
      once_reg <= once_next;
      tog_reg <= tog_next;
      wclk_out_reg <= supply_on && tog_next;
    end
  end

  // The subclock is foreign to SYS_CLK; only its rise is used, and only
  // the second and third stages feed the edge detector.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_s3_reg <= 1'b0;
    end else begin
      sub_s1_reg <= SUBCLK;
      sub_s2_reg <= sub_s1_reg;
      sub_s3_reg <= sub_s2_reg;
    end
  end

  // Watch timer.
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      wpresc_reg <= 11'h000;
      wcnt_reg <= 5'h00;
    end else begin
      wpresc_reg <= wpresc_next;
      wcnt_reg <= wcnt_next;
    end
  end

endmodule : itwc_top
`default_nettype wire

// ===== tb/itwc_checker.sv
// Concurrent checks on the ports of the interval timer top.
// Assumes a bind to itwc_top with one clock and an active-low reset.
`timescale 1ns/100ps
`default_nettype none
module itwc_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic WATCH_CLK_OUT,
  input wire logic IRQ
);
  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(8'h14);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  wire logic wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
                     && S_AXI_WREADY;
  wire logic rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  chk_reset_quiet: assert property ($rose(RESETN) |-> !IRQ
    && !WATCH_CLK_OUT && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("outputs active after reset");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write resp lost");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data lost");
  // Decode looks at word addresses only, and the write answer rises on the
  // same edge at which the joined address and data are acted on.
  chk_wr_unmapped: assert property (wr_go
    && S_AXI_AWADDR[ADDR_W-1:2] > LAST[ADDR_W-1:2]
    |-> ##2 S_AXI_BVALID && S_AXI_BRESP == 2'h2)
    else $error("unmapped write");
  chk_wr_mapped: assert property (wr_go && S_AXI_AWADDR <= LAST
    && S_AXI_AWADDR[1:0] == 2'h0 |-> ##2 S_AXI_BVALID && S_AXI_BRESP == 2'h0)
    else $error("mapped write refused");
  chk_rd_unmapped: assert property (rd_go
    && S_AXI_ARADDR[ADDR_W-1:2] > LAST[ADDR_W-1:2]
    |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read");
  chk_mode_spare: assert property (rd_go && S_AXI_ARADDR == '0
    |=> S_AXI_RVALID && (S_AXI_RDATA & ~32'h17) == 32'h0)
    else $error("mode spare bits set");
  // Phase lengths of the watch clock, saturating. A high phase never
  // outlasts the low phase before it, so a toggle skipped while high shows up here;
  // a stop only shortens a high phase or lengthens a low one.
  logic wclk_q;
  logic [15:0] ph_len;
  logic [15:0] lo_len;
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      wclk_q <= 1'b0;
      ph_len <= 16'h0000;
      lo_len <= 16'hFFFF;
    end else begin
      wclk_q <= WATCH_CLK_OUT;
      if (WATCH_CLK_OUT != wclk_q) begin
        ph_len <= 16'h0001;
        if (WATCH_CLK_OUT) begin
          lo_len <= ph_len;
        end
      end else if (ph_len != 16'hFFFF) begin
        ph_len <= ph_len + 16'h0001;
      end
    end
  end
  chk_wclk_width: assert property (!WATCH_CLK_OUT && wclk_q
    |-> ph_len <= lo_len) else $error("watch clock high phase too long");
  cov_write: cover property (wr_go);
  cov_read: cover property (rd_go);
  cov_irq: cover property ($rose(IRQ));
  cov_wclk: cover property ($rose(WATCH_CLK_OUT));
endmodule : itwc_checker
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the interval timer with watch clock.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "itwc_params.svh"
module testbench;
  logic clk = 1'b0, rstn = 1'b0, sub = 1'b0;
  logic [2:0] sdiv = 3'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awr, wrd, bv, arr, rv, wclk, irq;
  logic [1:0] bres, rres, rsp;
  logic [31:0] rdat, rd_v;
  int miscompares = 0, cmp_count = 0, n;
  itwc_top DUT (
    .SYS_CLK(clk), .RESETN(rstn), .SUBCLK(sub),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bres), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rres),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .WATCH_CLK_OUT(wclk),
    .IRQ(irq)
  );
  always #5 clk = ~clk;
  // Slow subclock of sixteen cycles, stepped on the clock edge.
  always @(posedge clk) begin
    sdiv <= sdiv + 3'h1;
    if (sdiv == 3'h7) sub <= ~sub;
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    // Ready is raised only once the answer is seen, so the answer must wait.
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv && !brd) brd <= 1'b1;
    end while (!(bv && brd));
    brd <= 1'b0;
    rsp = bres;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && !rrd) rrd <= 1'b1;
    end while (!(rv && rrd));
    rrd <= 1'b0;
    rd_v = rdat;
    rsp = rres;
  endtask : rd
  // Counts cycles up to the next rising edge of the watch clock.
  task automatic edge_wait(output int c);
    c = 0;
    while (wclk) begin
      @(posedge clk);
      c++;
    end
    while (!wclk) begin
      @(posedge clk);
      c++;
    end
  endtask : edge_wait
  task automatic t_reset;
    for (int a = 0; a < 5; a++) begin
      rd(8'(a * 4));
      check("reset value", rd_v, 32'h0);
    end
    rd(`ITWC_OFS_COUNT);
    check("stopped count", rd_v, 32'h1);
  endtask : t_reset
  task automatic t_regs;
    wr(`ITWC_OFS_MODE, 32'hFF, 4'hF);
    rd(`ITWC_OFS_MODE);
    check("mode bits", rd_v, 32'h17);
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
    rd(`ITWC_OFS_COUNT);
    check("cleared count", rd_v & 32'hFF, 32'h1);
    wr(`ITWC_OFS_CMP, 32'hAB, 4'hF);
    wr(`ITWC_OFS_CMP, 32'h55, 4'hE);
    rd(`ITWC_OFS_CMP);
    check("compare byte", rd_v, 32'hAB);
    wr(8'h40, 32'h1, 4'hF);
    check("unmapped write", 32'(rsp), 32'h2);
    rd(8'h40);
    check("unmapped read", {rd_v[29:0], rsp}, 32'h2);
  endtask : t_regs
  task automatic t_period;
    logic [1:0] sel;
    int nn;
    for (int i = 0; i < 5; i++) begin
      sel = 2'(i % 4);
      nn = (i == 4) ? 256 : 3;
      wr(`ITWC_OFS_CMP, 32'(8'(nn)), 4'hF);
      wr(`ITWC_OFS_MODE, {30'h0, sel}, 4'hF);
      wr(`ITWC_OFS_MODE, {27'h0, 1'b1, 2'b00, sel}, 4'hF);
      edge_wait(n);
      edge_wait(n);
      check("period", 32'(n), 32'((2 << sel) * nn));
      wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
    end
    // Halving N while the select value grows must keep the output rate.
    nn = 12;
    sel = 2'h0;
    while (nn % 2 == 0 && sel < 2'h3) begin
      nn = nn / 2;
      sel = sel + 2'h1;
    end
    wr(`ITWC_OFS_CMP, 32'(8'(nn)), 4'hF);
    wr(`ITWC_OFS_MODE, {30'h0, sel}, 4'hF);
    wr(`ITWC_OFS_MODE, {27'h0, 1'b1, 2'b00, sel}, 4'hF);
    edge_wait(n);
    edge_wait(n);
    check("scaled period", 32'(n), 32'd24);
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
  endtask : t_period
  task automatic t_irq;
    wr(`ITWC_OFS_CMP, 32'h5, 4'hF);
    wr(`ITWC_OFS_MASK, 32'h1, 4'hF);
    wr(`ITWC_OFS_MODE, 32'h10, 4'hF);
    for (n = 0; n < 64 && !irq; n++) @(posedge clk);
    check("match irq", {31'h0, irq}, 32'h1);
    wr(`ITWC_OFS_MASK, 32'h0, 4'hF);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
    wr(`ITWC_OFS_STAT, 32'h7, 4'hF);
    rd(`ITWC_OFS_STAT);
    check("cleared status", rd_v, 32'h0);
    // A compare of one may match once only, so a cleared flag stays clear.
    wr(`ITWC_OFS_CMP, 32'h1, 4'hF);
    wr(`ITWC_OFS_MODE, 32'h10, 4'hF);
    wr(`ITWC_OFS_STAT, 32'h1, 4'hF);
    repeat (40) @(posedge clk);
    rd(`ITWC_OFS_STAT);
    check("single match", rd_v, 32'h0);
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
  endtask : t_irq
  task automatic t_watch;
    wr(`ITWC_OFS_CMP, 32'h2, 4'hF);
    wr(`ITWC_OFS_MODE, 32'h14, 4'hF);
    for (n = 0; n < 40 && !wclk; n++) @(posedge clk);
    check("supply off", 32'(n), 32'd40);
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
    wr(`ITWC_OFS_MODE, 32'h10, 4'hF);
    for (int s = 1; s >= 0; s--) begin
      wr(`ITWC_OFS_STAT, 32'h7, 4'hF);
      wr(`ITWC_OFS_WMODE, {24'h0, 1'(s), 7'h0F}, 4'hF);
      repeat (400) @(posedge clk);
      rd(`ITWC_OFS_STAT);
      check("watch flags", rd_v & 32'h6, 32'h6);
      wr(`ITWC_OFS_WMODE, 32'h0, 4'hF);
      rd(`ITWC_OFS_COUNT);
      check("watch count", rd_v & 32'h1F000, 32'h0);
    end
    wr(`ITWC_OFS_MODE, 32'h0, 4'hF);
  endtask : t_watch
  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_period();
    t_irq();
    t_watch();
    close_out();
  end
endmodule : testbench
bind itwc_top itwc_checker #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire
